// File: design/vtc_pkg.sv
// vtc_pkg: constants, states and helpers of the trim and calibration bank
// assumes byte-wide registers behind an i2c management port on clk
//
// Overview of operation
// - trim bits 7:4 scale input current in 0.5 percent steps from -3.5
// - trim bits 3:0 add offset to current; code 1000b adds 0.25 a
// - negative trimmed current is not clamped; it wraps down from ceiling
// - target write moves output only in i2c level mode, else just stored
// - target driven changes ramp at a quarter of the fast slew rate
// - target writes nacked during soft-start or soft-stop, acked afterwards
// - new target takes effect at once, abandoning any transition underway
// - target code is voltage-id with 5 or 10 mv step per protocol bits
// - readback returns last commanded level from i2c or bus, no offset
// - readback always equals the voltage-id bus copy of the level
// - offset register adds signed offset, ramped at quarter fast rate
// - protocol 01b or 10b gives offset weight 0.5 mv per lsb
// - protocol 00b or 11b gives offset weight 1.0 mv per lsb
// - offset effect depends on the output-control selection bits
// - compensation bits 7:4 select ac_path_gain, codes 0 to 1011b valid
// - compensation bits 3:0 select ac load line, all codes valid
// - selection 00b bus owns all and nacks offset; 01b split; 1xb i2c
package vtc_pkg;
  localparam logic [7:0] REG_IIN_TRIM = 8'hA5;
  localparam logic [7:0] REG_VOUT_TGT = 8'hA6;
  localparam logic [7:0] REG_READBACK = 8'hA7;
  localparam logic [7:0] REG_OFFSET   = 8'hA8;
  localparam logic [7:0] REG_COMP     = 8'hA9;
  localparam logic [7:0] RESET_VAL    = 8'h00;
  localparam logic [7:0] UNMAPPED_RD  = 8'hFF;
  localparam int         HI_MSB       = 7;
  localparam int         HI_LSB       = 4;
  localparam int         LO_MSB       = 3;
  localparam int         LO_LSB       = 0;
  localparam logic [1:0] CTRL_VID_BUS = 2'h0;
  localparam logic [1:0] CTRL_I2C     = 2'h2;
  localparam logic [1:0] CTRL_I2C_ALT = 2'h3;
  localparam logic [1:0] PROTO_FINE_A = 2'h1;
  localparam logic [1:0] PROTO_FINE_B = 2'h2;
  localparam int         SLEW_DIV     = 4;
  localparam logic [1:0] SLEW_LAST    = 2'(SLEW_DIV - 1);
  localparam logic signed [4:0]  GAIN_UNITY = 5'sh07;
  localparam logic signed [16:0] GAIN_DIV   = 17'sh000C8;
  localparam logic signed [4:0]  OFS_POS_BIAS = 5'sh07;
  localparam logic signed [4:0]  OFS_NEG_BIAS = 5'sh08;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_DATA,
    ST_DATA_ACK, ST_READ, ST_READ_ACK, ST_IGNORE
  } vtc_i2c_state_t;

  function automatic logic i2c_owns_level(input logic [1:0] ctrl);
    return ctrl == CTRL_I2C || ctrl == CTRL_I2C_ALT;
  endfunction

  function automatic logic fine_lsb(input logic [1:0] proto);
    return proto == PROTO_FINE_A || proto == PROTO_FINE_B;
  endfunction
endpackage

// File: design/vtc_ramp.sv
// vtc_ramp: walks a level one code toward its target every fourth tick
// assumes slew_tick is a one-cycle pulse on clk at the fast slew rate
`timescale 1ns/1ns
module vtc_ramp
  import vtc_pkg::*;
#(
  parameter bit SIGNED_LVL = 1'b0 // compare codes as two's complement
) (
  input  wire logic       clk,       // core clock
  input  wire logic       sys_rst,   // async reset, high
  input  wire logic       init_stb,  // jump straight to init_val
  input  wire logic [7:0] init_val,  // level taken on init_stb
  input  wire logic [7:0] target,    // level to head for
  input  wire logic       slew_tick, // fast-rate step pulse
  output logic      [7:0] level      // present level
);
  logic [1:0] div_q;
  logic       step;
  logic       above;
  logic       below;

  always_comb begin
    above = SIGNED_LVL ? ($signed(target) > $signed(level)) : (target > level);
    below = SIGNED_LVL ? ($signed(target) < $signed(level)) : (target < level);
    step  = slew_tick && div_q == SLEW_LAST;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) div_q <= 2'h0;
    else if (slew_tick) div_q <= div_q + 2'h1;
  end

  // target is followed live, so a new one redirects a ramp in flight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) level <= RESET_VAL;
    else if (init_stb) level <= init_val;
    else if (step && above) level <= level + 8'h01;
    else if (step && below) level <= level - 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence go_up;   step && above && !init_stb; endsequence
  sequence go_down; step && below && !init_stb; endsequence

  quarter_rate_a: assert property (
    !init_stb && !(slew_tick && div_q == 2'h3) |=> $stable(level))
    else $error("level moved off the quarter-rate step");
  heads_up_a: assert property (
    go_up |=> level == $past(level) + 8'h01)
    else $error("level did not step up toward target");
  heads_down_a: assert property (
    go_down |=> level == $past(level) - 8'h01)
    else $error("level did not step down toward target");
endmodule

// File: design/vtc_itrim.sv
// vtc_itrim: applies gain and offset trim to the input-current report
// assumes adc_iin is on clk with 0.25 a per lsb, same lsb as the report
`timescale 1ns/1ns
module vtc_itrim
  import vtc_pkg::*;
(
  input  wire logic       clk,       // core clock
  input  wire logic       sys_rst,   // async reset, high
  input  wire logic [9:0] adc_iin,   // converted input current
  input  wire logic [3:0] gain_code, // gain trim field
  input  wire logic [3:0] ofs_code,  // offset trim field
  input  wire logic [9:0] ceiling,   // wrap limit of the report
  output logic      [9:0] report     // trimmed current report
);
  logic signed [4:0]  gain_adj;
  logic signed [16:0] prod;
  logic signed [16:0] corr;
  logic signed [4:0]  ofs_adj;
  logic signed [12:0] sum;
  logic        [9:0]  report_d;

  always_comb begin
    gain_adj = $signed({1'b0, gain_code}) - GAIN_UNITY;
    prod     = $signed({7'h00, adc_iin}) * gain_adj;
    corr     = prod / GAIN_DIV;
    ofs_adj  = ofs_code[3] ? $signed({1'b0, ofs_code}) - OFS_POS_BIAS
                           : $signed({1'b0, ofs_code}) - OFS_NEG_BIAS;
    sum      = $signed({3'h0, adc_iin}) + 13'(corr) + ofs_adj;
    if (sum < 13'sh0000) report_d = ceiling + sum[9:0];
    else if (sum > 13'sh03FF) report_d = 10'h3FF;
    else report_d = sum[9:0];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) report <= 10'h000;
    else report <= report_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  gain_step_a: assert property (
    gain_code == 4'hF && ofs_code == 4'h8 && adc_iin == 10'h0C8
    |=> report == 10'h0D1)
    else $error("gain trim top code is not plus four percent");
  offset_step_a: assert property (
    adc_iin == 10'h000 && ofs_code == 4'h8 |=> report == 10'h001)
    else $error("offset code 1000b is not a quarter amp");
  wrap_down_a: assert property (
    adc_iin < 10'h008 && ofs_code == 4'h0
    |=> report == $past(ceiling) + $past(adc_iin) - 10'h008)
    else $error("negative sum did not wrap down from the ceiling");
endmodule

// File: design/vtc_regs.sv
// vtc_regs: i2c reached trim, target, offset and compensation registers
// assumes scl and sda are open-drain pins resolved outside the block;
// every other input comes from logic on clk
`timescale 1ns/1ns
module vtc_regs
  import vtc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // bus address, value arbitrary
) (
  input  wire logic       clk,          // 10 mhz core clock
  input  wire logic       sys_rst,      // async reset, high
  input  wire logic       scl_i,        // i2c clock pin level
  input  wire logic       sda_i,        // i2c data pin level
  output logic            sda_o,        // i2c data drive value
  output logic            sda_oe_n,     // low while pulling sda low
  input  wire logic [7:0] nvm_iin_trim, // stored current trim
  input  wire logic [7:0] nvm_vout_tgt, // stored voltage target
  input  wire logic [7:0] nvm_offset,   // stored offset trim
  input  wire logic [7:0] nvm_comp,     // stored compensation
  input  wire logic [7:0] nvm_boot_lvl, // boot level code
  input  wire logic [1:0] vout_ctrl,    // output-control selection
  input  wire logic [1:0] protocol_identifier, // step select
  input  wire logic       soft_busy,    // soft-start or soft-stop on
  input  wire logic [7:0] vid_bus_lvl,  // level from voltage-id bus
  input  wire logic       vid_bus_stb,  // new vid_bus_lvl command
  input  wire logic [7:0] vid_bus_ofs,  // offset from voltage-id bus
  input  wire logic       slew_tick,    // fast-rate step pulse
  input  wire logic [9:0] adc_iin,      // converted input current
  input  wire logic [9:0] input_current_ceiling, // report wrap limit
  output logic      [9:0] input_current_report,  // trimmed current
  output logic      [7:0] out_level,    // ramped level code
  output logic      [7:0] out_offset,   // ramped signed offset
  output logic            fine_step,    // 5 mv and 0.5 mv lsb
  output logic      [3:0] ac_path_gain, // ac_path_gain select
  output logic      [3:0] ac_load_line, // ac load-line select
  output logic      [7:0] readback_31h  // level copy for the vid bus
);
  logic           scl_s1_q;
  logic           scl_s2_q;
  logic           scl_s3_q;
  logic           sda_s1_q;
  logic           sda_s2_q;
  logic           sda_s3_q;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_det;
  logic           stop_det;
  vtc_i2c_state_t st_q;
  logic [2:0]     cnt_q;
  logic [7:0]     sh_q;
  logic [7:0]     byte_in;
  logic           byte_end;
  logic           ack_q;
  logic           rw_q;
  logic [7:0]     cmd_q;
  logic [7:0]     rd_q;
  logic [7:0]     rd_word;
  logic           sda_oe_n_q;
  logic           reg_mapped;
  logic           wr_ok;
  logic           wr_stb;
  logic           load_q;
  logic [7:0]     iin_trim_q;
  logic [7:0]     vout_tgt_q;
  logic [7:0]     offset_q;
  logic [7:0]     comp_q;
  logic [7:0]     level_rb_q;
  logic           fine_q;
  logic [7:0]     off_tgt;
  logic [7:0]     off_init;

  // pin synchronisers; edges are taken from the second and third stages
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  always_comb begin
    scl_rise   = scl_s2_q && !scl_s3_q;
    scl_fall   = !scl_s2_q && scl_s3_q;
    start_det  = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
    stop_det   = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;
    byte_in    = {sh_q[6:0], sda_s2_q};
    byte_end   = cnt_q == BIT_LAST;
    reg_mapped = byte_in >= REG_IIN_TRIM && byte_in <= REG_COMP;
  end

  // write acceptance, settled before the data byte's acknowledge slot
  always_comb begin
    wr_ok = 1'b1;
    if (cmd_q == REG_VOUT_TGT) wr_ok = !soft_busy;
    else if (cmd_q == REG_OFFSET) wr_ok = vout_ctrl != CTRL_VID_BUS;
    else if (cmd_q == REG_READBACK) wr_ok = 1'b0;
    wr_stb = scl_rise && !start_det && !stop_det && st_q == ST_DATA
             && byte_end && wr_ok;
  end

  always_comb begin
    case (cmd_q)
      REG_IIN_TRIM: rd_word = iin_trim_q;
      REG_VOUT_TGT: rd_word = vout_tgt_q;
      REG_READBACK: rd_word = level_rb_q;
      REG_OFFSET:   rd_word = offset_q;
      REG_COMP:     rd_word = comp_q;
      default:      rd_word = UNMAPPED_RD;
    endcase
  end

  // transaction sequencer, advanced on each sampled scl rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q  <= ST_IDLE;
      cnt_q <= 3'h0;
      sh_q  <= 8'h00;
      ack_q <= 1'b0;
      rw_q  <= 1'b0;
      cmd_q <= 8'h00;
    end else if (stop_det) begin
      st_q  <= ST_IDLE;
      ack_q <= 1'b0;
    end else if (start_det) begin
      st_q  <= ST_ADDR;
      cnt_q <= 3'h0;
      ack_q <= 1'b0;
    end else if (scl_rise) begin
      cnt_q <= cnt_q + 3'h1;
      sh_q  <= byte_in;
      unique case (st_q)
        ST_ADDR: if (byte_end) begin
          ack_q <= byte_in[7:1] == DEV_ADDR;
          rw_q  <= byte_in[0];
          st_q  <= byte_in[7:1] == DEV_ADDR ? ST_ADDR_ACK : ST_IGNORE;
        end
        ST_ADDR_ACK: begin
          ack_q <= 1'b0;
          cnt_q <= 3'h0;
          st_q  <= rw_q ? ST_READ : ST_CMD;
        end
        ST_CMD: if (byte_end) begin
          cmd_q <= byte_in;
          ack_q <= reg_mapped;
          st_q  <= ST_CMD_ACK;
        end
        ST_CMD_ACK: begin
          ack_q <= 1'b0;
          cnt_q <= 3'h0;
          st_q  <= ack_q ? ST_DATA : ST_IGNORE;
        end
        ST_DATA: if (byte_end) begin
          ack_q <= wr_ok;
          st_q  <= ST_DATA_ACK;
        end
        ST_DATA_ACK: begin
          ack_q <= 1'b0;
          st_q  <= ST_IGNORE;
        end
        ST_READ: if (byte_end) begin
          st_q <= ST_READ_ACK;
        end
        ST_READ_ACK: st_q <= ST_IGNORE;
        ST_IDLE, ST_IGNORE: st_q <= st_q;
      endcase
    end
  end

  // sda changes only after scl falls; a read byte goes out msb first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_oe_n_q <= 1'b1;
      rd_q       <= UNMAPPED_RD;
    end else begin
      if (scl_rise && !start_det && !stop_det && st_q == ST_ADDR_ACK && rw_q)
        rd_q <= rd_word;
      else if (scl_fall && st_q == ST_READ)
        rd_q <= {rd_q[6:0], 1'b1};
      if (start_det || stop_det) sda_oe_n_q <= 1'b1;
      else if (scl_fall && st_q == ST_READ) sda_oe_n_q <= rd_q[7];
      else if (scl_fall) sda_oe_n_q <= !ack_q;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = sda_oe_n_q;

  // one-cycle window after release that copies the stored values in
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) load_q <= 1'b1;
    else load_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      iin_trim_q <= RESET_VAL;
      vout_tgt_q <= RESET_VAL;
      offset_q   <= RESET_VAL;
      comp_q     <= RESET_VAL;
    end else if (load_q) begin
      iin_trim_q <= nvm_iin_trim;
      vout_tgt_q <= nvm_vout_tgt;
      offset_q   <= nvm_offset;
      comp_q     <= nvm_comp;
    end else if (wr_stb) begin
      if (cmd_q == REG_IIN_TRIM) iin_trim_q <= byte_in;
      if (cmd_q == REG_VOUT_TGT) vout_tgt_q <= byte_in;
      if (cmd_q == REG_OFFSET) offset_q <= byte_in;
      if (cmd_q == REG_COMP) comp_q <= byte_in;
    end
  end

  // last commanded level from whichever side owns it, offset excluded
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) level_rb_q <= RESET_VAL;
    else if (load_q) level_rb_q <= nvm_boot_lvl;
    else if (wr_stb && cmd_q == REG_VOUT_TGT && i2c_owns_level(vout_ctrl))
      level_rb_q <= byte_in;
    else if (vid_bus_stb && !i2c_owns_level(vout_ctrl))
      level_rb_q <= vid_bus_lvl;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) fine_q <= 1'b0;
    else fine_q <= fine_lsb(protocol_identifier);
  end

  always_comb begin
    off_tgt  = vout_ctrl == CTRL_VID_BUS ? vid_bus_ofs : offset_q;
    off_init = vout_ctrl == CTRL_VID_BUS ? vid_bus_ofs : nvm_offset;
  end

  assign fine_step    = fine_q;
  assign readback_31h = level_rb_q;
  assign ac_path_gain = comp_q[HI_MSB:HI_LSB];
  assign ac_load_line = comp_q[LO_MSB:LO_LSB];

  vtc_ramp #(
    .SIGNED_LVL (1'b0)
  ) u_level_ramp (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .init_stb  (load_q),
    .init_val  (nvm_boot_lvl),
    .target    (level_rb_q),
    .slew_tick (slew_tick),
    .level     (out_level)
  );

  vtc_ramp #(
    .SIGNED_LVL (1'b1)
  ) u_offset_ramp (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .init_stb  (load_q),
    .init_val  (off_init),
    .target    (off_tgt),
    .slew_tick (slew_tick),
    .level     (out_offset)
  );

  vtc_itrim u_itrim (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .adc_iin   (adc_iin),
    .gain_code (iin_trim_q[HI_MSB:HI_LSB]),
    .ofs_code  (iin_trim_q[LO_MSB:LO_LSB]),
    .ceiling   (input_current_ceiling),
    .report    (input_current_report)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence data_end(logic [7:0] reg_a);
    scl_rise && !start_det && !stop_det && st_q == ST_DATA && byte_end
    && cmd_q == reg_a;
  endsequence

  target_nack_a: assert property (
    data_end(REG_VOUT_TGT) ##0 soft_busy |=> !ack_q && st_q == ST_DATA_ACK)
    else $error("target write acked during soft ramp");
  target_ack_a: assert property (
    data_end(REG_VOUT_TGT) ##0 !soft_busy
    |=> ack_q && st_q == ST_DATA_ACK)
    else $error("target write not acked after soft-start");
  ack_drive_a: assert property (
    scl_fall && ack_q && !start_det && !stop_det |=> !sda_oe_n)
    else $error("acknowledge not driven on sda");
  offset_nack_a: assert property (
    data_end(REG_OFFSET) ##0 vout_ctrl == CTRL_VID_BUS
    |=> !ack_q ##1 $stable(offset_q))
    else $error("offset write taken while the bus owns it");
  retarget_a: assert property (
    data_end(REG_VOUT_TGT) ##0 !soft_busy && !load_q
    |=> vout_tgt_q == $past(byte_in)
        && (i2c_owns_level($past(vout_ctrl))
            ? level_rb_q == $past(byte_in) : 1'b1))
    else $error("target write did not store or retarget");
  store_only_a: assert property (
    data_end(REG_VOUT_TGT) ##0 !i2c_owns_level(vout_ctrl) && !vid_bus_stb
    |=> $stable(level_rb_q))
    else $error("target write moved a bus-owned level");
  bus_level_a: assert property (
    vid_bus_stb && !i2c_owns_level(vout_ctrl) && !load_q
    |=> level_rb_q == $past(vid_bus_lvl))
    else $error("readback missed a bus level command");
  readback_copy_a: assert property (
    scl_rise && !start_det && !stop_det && st_q == ST_ADDR_ACK && rw_q
    && cmd_q == REG_READBACK |=> rd_q == readback_31h)
    else $error("readback differs from the bus copy");
  fine_weight_a: assert property (
    protocol_identifier == 2'h1 || protocol_identifier == 2'h2 |=> fine_step)
    else $error("fine offset weight not selected");
  coarse_weight_a: assert property (
    protocol_identifier == 2'h0 || protocol_identifier == 2'h3 |=> !fine_step)
    else $error("coarse offset weight not selected");
  comp_fields_a: assert property (
    data_end(REG_COMP) |=> ac_path_gain == $past(byte_in[7:4])
                           && ac_load_line == $past(byte_in[3:0]))
    else $error("compensation fields not updated");
  nvm_load_a: assert property (
    load_q |=> iin_trim_q == $past(nvm_iin_trim) && comp_q == $past(nvm_comp)
               && level_rb_q == $past(nvm_boot_lvl))
    else $error("stored values not loaded after reset");
  offset_source_a: assert property (
    vout_ctrl == CTRL_VID_BUS && !load_q
    && $signed(out_offset) > $signed(vid_bus_ofs)
    |=> $signed(out_offset) <= $signed($past(out_offset)))
    else $error("offset moved away from the bus offset");
endmodule

// File: tb/vtc_i2c_host.sv
// vtc_i2c_host: behavioural i2c host that writes and reads one byte
// assumes sda is open drain with a pull-up resolved by the bench
`timescale 1ns/1ns
module vtc_i2c_host #(
  parameter logic [6:0] ADDR = 7'h2A // device address
) (
  input  wire logic clk,     // core clock
  input  wire logic sda_i,   // resolved sda level
  output logic      scl,     // i2c clock, idles high
  output logic      sda_pd_n // low while the host pulls sda low
);
  initial scl = 1'b1;
  initial sda_pd_n = 1'b1;
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  // data set while scl is low, sampled late in scl high
  task automatic bit_io(input logic b, output logic r);
    sda_pd_n = b;
    half();
    scl = 1'b1;
    half();
    r = sda_i;
    scl = 1'b0;
  endtask
  // doubles as repeated start when entered with scl low
  task automatic start();
    sda_pd_n = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pd_n = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_pd_n = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pd_n = 1'b1;
    half();
  endtask
  task automatic xfer(input logic [7:0] v, output logic [7:0] r,
                      output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
    bit_io(1'b1, nak);
  endtask
  // nak holds the ack slot levels: address, command, data or read address
  task automatic op(input logic rw, input logic [7:0] c, input logic [7:0] v,
                    output logic [7:0] d, output logic [2:0] nak);
    logic n;
    start();
    xfer({ADDR, 1'b0}, d, nak[2]);
    xfer(c, d, nak[1]);
    if (rw) start();
    xfer(rw ? {ADDR, 1'b1} : v, d, nak[0]);
    if (rw) xfer(8'hFF, d, n);
    stop();
  endtask
endmodule

// File: tb/testbench.sv
// testbench: random trims and fixed targets sent through the i2c host model
// assumes vtc_pkg, vtc_regs and vtc_i2c_host are compiled first
`timescale 1ns/1ns
module testbench;
  logic       clk, sys_rst, scl, sda_o, sda_oe_n, pd_n, busy, stb, tick;
  logic       tick_en, fine;
  logic [7:0] nvm [5];
  logic [7:0] mdl [5];
  logic [7:0] lvl, ofs, out_level, out_offset, rb31, l1, d;
  logic [1:0] ctrl, proto;
  logic [3:0] gain, ll;
  logic [9:0] adc, ceil, report;
  logic [2:0] nak;
  wire        sda = pd_n & (sda_oe_n | sda_o);
  int         n_fail, compares, cyc, g, o;
  int         seed = 32'h763F;
  always #50 clk = ~clk;
  always @(negedge clk) tick <= tick_en & ~tick;
  always @(posedge clk) if (++cyc == 40000) final_report();
  vtc_regs DUT (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .nvm_iin_trim(nvm[0]),
    .nvm_vout_tgt(nvm[1]), .nvm_offset(nvm[3]), .nvm_comp(nvm[4]),
    .nvm_boot_lvl(nvm[2]), .vout_ctrl(ctrl), .protocol_identifier(proto),
    .soft_busy(busy), .vid_bus_lvl(lvl), .vid_bus_stb(stb),
    .vid_bus_ofs(ofs), .slew_tick(tick), .adc_iin(adc),
    .input_current_ceiling(ceil), .input_current_report(report),
    .out_level(out_level), .out_offset(out_offset), .fine_step(fine),
    .ac_path_gain(gain), .ac_load_line(ll), .readback_31h(rb31));
  vtc_i2c_host host (.clk(clk), .sda_i(sda), .scl(scl), .sda_pd_n(pd_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr_chk(input logic [7:0] c, v, input logic [2:0] exp);
    host.op(1'b0, c, v, d, nak);
    check(nak, exp);
    if (exp == 3'b000) mdl[int'(c) - 165] = v;
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [2:0] en,
                        input logic [7:0] ed);
    host.op(1'b1, c, 8'h00, d, nak);
    check({nak, d}, {en, ed});
  endtask
  function automatic logic [9:0] trim_mdl(int a, int gc, int oc, int c);
    int s;
    s = a + a * (gc - 7) / 200 + (oc < 8 ? oc - 8 : oc - 7);
    if (s < 0) s = c + s;
    if (s > 1023) s = 1023;
    return 10'(s);
  endfunction
  task automatic final_report();
    if (cyc >= 40000) n_fail++;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    {sys_rst, busy, stb, tick_en} = 4'b1000;
    {ctrl, proto, lvl, ofs} = 20'h80000;
    ceil = 10'd128;
    adc = 10'd500;
    foreach (nvm[k]) nvm[k] = 8'($random(seed));
    nvm[2] = 8'h40;
    nvm[4] = 8'hB0;
    mdl = nvm;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 5; k++) rd_chk(8'(165 + k), 0, mdl[k]);
    check(rb31, 8'h40);
    check({gain, ll}, nvm[4]);
    rd_chk(8'hB0, 3'b010, 8'hFF);
    wr_chk(8'hA7, 8'h5A, 3'b001);
    for (int k = 0; k < 12; k++) begin
      wr_chk(8'hA9, 8'(k * 17 + 4), 0);
      check({gain, ll}, mdl[4]);
    end
    for (int k = 0; k < 6; k++) begin
      g = (k == 0) ? 0 : {$random(seed)} % 16;
      o = 8 + {$random(seed)} % 8;
      adc = (k == 0) ? 10'd1000 : 10'(100 + {$random(seed)} % 800);
      wr_chk(8'hA5, 8'(g * 16 + o), 0);
      check(report, trim_mdl(adc, g, o, ceil));
    end
    adc = 10'h000;
    wr_chk(8'hA5, 8'h08, 0);
    check(report, trim_mdl(adc, 0, 8, ceil));
    adc = 10'h0C8;
    wr_chk(8'hA5, 8'hF8, 0);
    check(report, trim_mdl(adc, 15, 8, ceil));
    adc = 10'd3;
    wr_chk(8'hA5, 8'h70, 0);
    check(report, trim_mdl(adc, 7, 0, ceil));
    busy = 1'b1;
    wr_chk(8'hA6, 8'h90, 3'b001);
    busy = 1'b0;
    tick_en = 1'b1;
    wr_chk(8'hA6, 8'hC0, 0);
    check(rb31, 8'hC0);
    wr_chk(8'hA6, 8'h30, 0);
    l1 = out_level;
    repeat (16) @(negedge clk);
    check(out_level, l1 - 8'h02);
    repeat (800) @(negedge clk);
    check(out_level, 8'h30);
    ctrl = 2'h0;
    ofs = 8'hF0;
    wr_chk(8'hA8, 8'h11, 3'b001);
    wr_chk(8'hA6, 8'h55, 0);
    repeat (2100) @(negedge clk);
    check(out_offset, 8'hF0);
    check(out_level, 8'h30);
    lvl = 8'h38;
    stb = 1'b1;
    @(negedge clk);
    stb = 1'b0;
    rd_chk(8'hA7, 0, 8'h38);
    check(rb31, 8'h38);
    ctrl = 2'h1;
    wr_chk(8'hA8, 8'h0C, 0);
    repeat (1100) @(negedge clk);
    check(out_offset, 8'h0C);
    for (int k = 0; k < 4; k++) begin
      proto = 2'(k);
      repeat (2) @(negedge clk);
      check(fine, k == 1 || k == 2);
    end
    final_report();
  end
endmodule
